// ==== rtl/gci_pkg.sv ====
// constants shared by both ends of the 4-wire multiplexed data link
// assumes a 25 MHz system clock at each end
package gci_pkg;
   // =====================================================
   // clocking
   localparam int unsigned MCLK_HZ      = 25_000_000;
   localparam int unsigned BCLK_SLOW_HZ = 512_000;
   localparam int unsigned BCLK_FAST_HZ = 1_536_000;
   localparam int unsigned FRAME_HZ     = 8_000;
   // half bit-clock periods round down so the rate never falls short
   localparam logic [7:0]  HALF_SLOW    = 8'(MCLK_HZ / (2 * BCLK_SLOW_HZ));
   localparam logic [7:0]  HALF_FAST    = 8'(MCLK_HZ / (2 * BCLK_FAST_HZ));
   localparam int          HC_W         = 11;
   // bit-clock periods per frame, two per data bit
   localparam logic [10:0] HALVES_SLOW  = 11'(BCLK_SLOW_HZ / FRAME_HZ);
   localparam logic [10:0] HALVES_FAST  = 11'(BCLK_FAST_HZ / FRAME_HZ);
   localparam logic [10:0] DLY_HALVES   = 11'h002;
   localparam logic [10:0] NONDLY_HALVES = 11'h010;
   localparam logic [10:0] FSB_HALF     = 11'h010;
   // =====================================================
   // data
   localparam int          WORD_W       = 32;
   localparam int          FIFO_DEPTH   = 32;
   localparam logic [31:0] IDLE_WORD    = 32'hFFFFFFFF;
   localparam logic [4:0]  M_IDX_LO     = 5'h08;
   localparam logic [4:0]  M_IDX_HI     = 5'h0F;
   localparam logic [4:0]  CI_IDX_LO    = 5'h02;
   localparam logic [4:0]  CI_IDX_HI    = 5'h05;
   // =====================================================
   // controller registers
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_TIMING  = 8'h04;
   localparam logic [7:0]  ADDR_TXD     = 8'h08;
   localparam logic [7:0]  ADDR_RXD     = 8'h0C;
   localparam logic [7:0]  ADDR_STAT    = 8'h10;
   localparam int          CTRL_EN      = 0;
   localparam int          CTRL_MASTER  = 1;
   localparam int          CTRL_MODE    = 2;
   localparam int          CTRL_DLY     = 3;
   localparam int          CTRL_RATE    = 4;
   localparam int          CTRL_CH_LO   = 5;
   localparam logic [31:0] CTRL_RST     = 32'h00000000;
   localparam int          TIM_BITS_LO  = 0;
   localparam int          TIM_DIV_LO   = 16;
   localparam logic [31:0] TIM_RST      = {8'h00, HALF_SLOW, 7'h00, 9'(HALVES_SLOW / 2)};
   localparam int          STAT_NEW     = 0;
   localparam int          STAT_FCNT_LO = 8;
   localparam logic [2:0]  HSIZE_WORD   = 3'h2;
   typedef enum logic [1:0] {ST_WAIT = 2'b00, ST_RUN = 2'b01} frame_st_e;
endpackage : gci_pkg

// ==== rtl/gci_if.sv ====
// the four link wires plus strap pins between device end and controller end
// wires with no driver float high through the board pull-ups
`timescale 1ns/1ps
interface gci_if;
   logic bclk_dev_o, bclk_dev_oe, bclk_host_o, bclk_host_oe;
   logic fsa_dev_o, fsa_dev_oe, fsa_host_o, fsa_host_oe;
   logic lo_dev_o, lo_dev_oe, lo_host_o, lo_host_oe;
   logic bx_o, bx_oe, br_o, br_oe;
   logic sel_hi, sel_mid, ms_sel, mode_sel;
   logic bclk, primary_frame_sync, sel_lo, bx, br;
   // =====================================================
   // wire levels
   assign bclk   = bclk_dev_oe ? bclk_dev_o : (bclk_host_oe ? bclk_host_o : 1'b1);
   assign primary_frame_sync    = fsa_dev_oe ? fsa_dev_o : (fsa_host_oe ? fsa_host_o : 1'b1);
   assign sel_lo = lo_dev_oe ? lo_dev_o : (lo_host_oe ? lo_host_o : 1'b1);
   assign bx     = bx_oe ? bx_o : 1'b1;
   assign br     = ~(br_oe & ~br_o);
   modport dev (output bclk_dev_o, bclk_dev_oe, fsa_dev_o, fsa_dev_oe, lo_dev_o, lo_dev_oe, br_o, br_oe,
                input bclk, primary_frame_sync, sel_lo, sel_hi, sel_mid, ms_sel, mode_sel, bx, br);
   modport host (output bclk_host_o, bclk_host_oe, fsa_host_o, fsa_host_oe, lo_host_o, lo_host_oe,
                 output bx_o, bx_oe, sel_hi, sel_mid, ms_sel, mode_sel,
                 input bclk, primary_frame_sync, br);
endinterface : gci_if

// ==== rtl/gci_word_fifo.sv ====
// word fifo with valid/ready on both sides
// assumes one clock for both sides
`timescale 1ns/1ps
module gci_word_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic         i_mclk,
   input  wire logic         i_rst,
   // fill side
   input  wire logic [W-1:0] i_data,
   input  wire logic         i_valid,
   output      logic         o_ready,
   // drain side
   output      logic [W-1:0] o_data,
   output      logic         o_valid,
   input  wire logic         i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;
   // =====================================================
   // pointers; ready and valid are registered from the next count
   always_comb
   begin
      push  = i_valid & o_ready;
      pop   = i_ready & o_valid;
      wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
      rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_d = AW'(0) + cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_q    <= '0;
         rd_q    <= '0;
         cnt_q   <= '0;
         o_ready <= 1'b0;
         o_valid <= 1'b0;
      end
      else
      begin
         wr_q    <= wr_d;
         rd_q    <= rd_d;
         cnt_q   <= cnt_d;
         o_ready <= cnt_d != (AW+1)'(DEPTH);
         o_valid <= cnt_d != '0;
      end
   end
   always_ff @(posedge i_mclk)
   begin
      if (push)
         mem[wr_q] <= i_data;
   end
   assign o_data = mem[rd_q];
endmodule : gci_word_fifo

// ==== rtl/gci_dev_end.sv ====
// device end of the multiplexed data link: slot timing, open-drain answer line
// assumes link pins are asynchronous to i_mclk; straps are static
// Function
// - independent tx/rx d slots, 64 slots
// - d pair at bits 1-2,3-4,5-6,7-8
// - slot assignment off with unframed d clock
// - sourced tx and rx frames always aligned
// - mode pin low: four bytes per frame
// - up to eight channels, strap picks channel
// - four wires, two clocks per bit
// - frame sync rise restarts slot counter
// - drive on rise, sample second fall
// - open-drain answer, contention on m and c/i
// - master makes clock and syncs, channel 0
// - slave: system supplies clock, straps channel
// - single channel: 512 kHz, straps low
// - multiplex: clock n*512 kHz up to 6144 kHz
// - master pin; top pin picks rate; low pin syncs
// - frame sync marks slot start or spans it
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module gci_dev_end
   import gci_pkg::*;
(
   // clock and reset
   input  wire logic              i_mclk,
   input  wire logic              i_rst,
   // link
   gci_if.dev                     link,
   // words to answer on the line, one per frame
   input  wire logic [WORD_W-1:0] i_tx_word,
   input  wire logic              i_tx_valid,
   output      logic              o_tx_ready,
   // words sampled from the line
   output      logic [WORD_W-1:0] o_rx_word,
   output      logic              o_rx_valid,
   // d slot assignment
   input  wire logic [5:0]        i_dslot_in,
   input  wire logic [1:0]        i_dpair_in,
   input  wire logic [5:0]        i_dslot_out,
   input  wire logic [1:0]        i_dpair_out,
   input  wire logic              i_dport_unframed,
   // status
   output      logic              o_contention,
   input  wire logic              i_contention_clr
);
   localparam int SY_BCLK = 0;
   localparam int SY_FSA  = 1;
   localparam int SY_BX   = 2;
   localparam int SY_BR   = 3;
   localparam int SY_HI   = 4;
   localparam int SY_MID  = 5;
   localparam int SY_LO   = 6;
   localparam int SY_MS   = 7;
   localparam int SY_MODE = 8;
   logic [8:0]        pins, s1_q, s2_q, p_q;
   logic              master, rate_hi, gci;
   logic [2:0]        chan;
   logic [10:0]       halves;
   logic [7:0]        half_lim, div_q, div_d;
   logic              bclk_q, bclk_d, fsa_q, fsa_d, fsb_q, fsb_d;
   logic [HC_W-1:0]   mh_q, mh_d, hc_q, hc_d, hc_b;
   logic              m_rise, m_fall, m_fs, rise, fall, fs;
   frame_st_e         st_q, st_d;
   logic [WORD_W-1:0] out_q, out_d, cap_q, cap_d, rxw_d, f_data;
   logic              f_valid, pop, rxv_d, oe_q, oe_d, cont_d, cont_set;
   logic [5:0]        w_drv, w_smp;

   // {hit, word bit} for a bit of the frame; word bit 31 goes first in a channel, word bit 1 in a d slot
   function automatic logic [5:0] win(input logic [9:0] b, input logic g, input logic [2:0] ch,
                                      input logic [5:0] slot, input logic [1:0] pair, input logic unf);
      if (g)
         return {b[9:5] == {2'b00, ch}, ~b[4:0]};
      else
         return {~unf & (b[9:3] == {1'b0, slot}) & (b[2:1] == pair), 4'h0, ~b[0]};
   endfunction : win

   // =====================================================
   // word buffer, drained once per frame so it back-pressures the source
   gci_word_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_data  (i_tx_word),
      .i_valid (i_tx_valid),
      .o_ready (o_tx_ready),
      .o_data  (f_data),
      .o_valid (f_valid),
      .i_ready (pop)
   );

   // =====================================================
   // pin synchronisers; only s2_q and p_q feed logic
   assign pins = {link.mode_sel, link.ms_sel, link.sel_lo, link.sel_mid, link.sel_hi,
                  link.br, link.bx, link.primary_frame_sync, link.bclk};
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s1_q <= '0;
         s2_q <= '0;
         p_q  <= '0;
      end
      else
      begin
         s1_q <= pins;
         s2_q <= s1_q;
         p_q  <= s2_q;
      end
   end

   // =====================================================
   // timing source and frame logic
   always_comb
   begin
      master   = s2_q[SY_MS];
      rate_hi  = s2_q[SY_HI];
      gci      = ~s2_q[SY_MODE];
      chan     = master ? 3'h0 : {s2_q[SY_HI], s2_q[SY_MID], s2_q[SY_LO]};
      halves   = rate_hi ? HALVES_FAST : HALVES_SLOW;
      half_lim = (rate_hi ? HALF_FAST : HALF_SLOW) - 8'h01;
      div_d    = div_q;
      bclk_d   = bclk_q;
      mh_d     = mh_q;
      m_rise   = 1'b0;
      m_fall   = 1'b0;
      m_fs     = 1'b0;
      if (master)
      begin
         // one counter times both directions, so frames stay aligned
         if (div_q >= half_lim)
         begin
            div_d  = 8'h00;
            bclk_d = ~bclk_q;
            m_rise = ~bclk_q;
            m_fall = bclk_q;
            if (~bclk_q)
            begin
               m_fs = mh_q >= halves - 11'h001;
               mh_d = m_fs ? '0 : HC_W'(mh_q + 11'h001);
            end
         end
         else
            div_d = div_q + 8'h01;
      end
      else
      begin
         div_d  = 8'h00;
         bclk_d = 1'b0;
         mh_d   = '1;
      end
      fsa_d = master & (mh_d < DLY_HALVES);
      fsb_d = master & (mh_d >= FSB_HALF) & (mh_d < FSB_HALF + DLY_HALVES);
      rise  = master ? m_rise : (s2_q[SY_BCLK] & ~p_q[SY_BCLK]);
      fall  = master ? m_fall : (~s2_q[SY_BCLK] & p_q[SY_BCLK]);
      fs    = master ? m_fs : (s2_q[SY_FSA] & ~p_q[SY_FSA]);

      hc_b  = fs ? '0 : hc_q;
      st_d  = fs ? ST_RUN : st_q;
      pop   = fs & f_valid;
      out_d = fs ? (f_valid ? f_data : IDLE_WORD) : out_q;
      cap_d = fs ? IDLE_WORD : cap_q;
      hc_d  = hc_b;
      oe_d  = oe_q;
      rxw_d = o_rx_word;
      rxv_d = 1'b0;
      cont_set = 1'b0;
      w_drv = win(hc_b[HC_W-1:1], gci, chan, i_dslot_out, i_dpair_out, i_dport_unframed);
      w_smp = win(10'(hc_q[HC_W-1:1] - 10'h001), gci, chan, i_dslot_in, i_dpair_in, i_dport_unframed);
      if (rise)
      begin
         // two bit-clock periods per data bit
         if (hc_b != '1)
            hc_d = HC_W'(hc_b + 11'h001);
         if (!hc_b[0])
            oe_d = (st_d == ST_RUN) & w_drv[5] & ~out_d[w_drv[4:0]];
      end
      if (fall && !hc_q[0] && hc_q != '0 && st_q == ST_RUN)
      begin
         if (w_smp[5])
         begin
            cap_d[w_smp[4:0]] = s2_q[SY_BX];
            // released a one but the shared line reads zero
            if (gci && out_q[w_smp[4:0]] && !s2_q[SY_BR] &&
                ((w_smp[4:0] >= M_IDX_LO && w_smp[4:0] <= M_IDX_HI) ||
                 (w_smp[4:0] >= CI_IDX_LO && w_smp[4:0] <= CI_IDX_HI)))
               cont_set = 1'b1;
            if (w_smp[4:0] == 5'h00)
            begin
               rxw_d = cap_d;
               rxv_d = 1'b1;
            end
         end
      end
      // a new contention wins over a clear in the same cycle
      cont_d = (o_contention & ~i_contention_clr) | cont_set;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         div_q        <= '0;
         bclk_q       <= 1'b0;
         fsa_q        <= 1'b0;
         fsb_q        <= 1'b0;
         mh_q         <= '1;
         hc_q         <= '1;
         st_q         <= ST_WAIT;
         out_q        <= IDLE_WORD;
         cap_q        <= IDLE_WORD;
         oe_q         <= 1'b0;
         o_rx_word    <= IDLE_WORD;
         o_rx_valid   <= 1'b0;
         o_contention <= 1'b0;
      end
      else
      begin
         div_q        <= div_d;
         bclk_q       <= bclk_d;
         fsa_q        <= fsa_d;
         fsb_q        <= fsb_d;
         mh_q         <= mh_d;
         hc_q         <= hc_d;
         st_q         <= st_d;
         out_q        <= out_d;
         cap_q        <= cap_d;
         oe_q         <= oe_d;
         o_rx_word    <= rxw_d;
         o_rx_valid   <= rxv_d;
         o_contention <= cont_d;
      end
   end

   // =====================================================
   // link drivers; clock and syncs only while timing master
   assign link.bclk_dev_o  = bclk_q;
   assign link.bclk_dev_oe = master;
   assign link.fsa_dev_o   = fsa_q;
   assign link.fsa_dev_oe  = master;
   assign link.lo_dev_o    = fsb_q;
   assign link.lo_dev_oe   = master;
   assign link.br_o        = 1'b0;
   assign link.br_oe       = oe_q;
endmodule : gci_dev_end

// ==== rtl/gci_host_end.sv ====
// controller end: backplane timing, straps and one channel window, on ahb-lite
// assumes a single ahb-lite master and zero-wait answers
`timescale 1ns/1ps
module gci_host_end
   import gci_pkg::*;
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   // link
   gci_if.host              link,
   // ahb-lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output      logic        o_hreadyout,
   output      logic [31:0] o_hrdata,
   output      logic        o_hresp
);
   logic [2:0]  s1_q, s2_q, p_q;
   logic [31:0] ctrl_q, ctrl_d, tim_q, tim_d, txd_q, txd_d, rxd_q, rxd_d, cap_q, cap_d, rd_d;
   logic [7:0]  addr_q, div_q, div_d, fcnt_q, fcnt_d;
   logic        wr_q, act_q, ap, dm, gen, bclk_q, bclk_d, fsa_q, fsa_d, new_q, new_d;
   logic        g_rise, g_fall, g_fs, rise, fall, fs, bxo_q, bxo_d, bxe_q, bxe_d;
   logic [HC_W-1:0] mh_q, mh_d, hc_q, hc_d, hc_b, halves;
   logic [9:0]  bd, bs;
   // =====================================================
   // bus, timing and channel window
   always_comb
   begin
      ap     = i_hsel & i_htrans[1] & i_hready & (i_hsize == HSIZE_WORD);
      ctrl_d = ctrl_q;
      tim_d  = tim_q;
      txd_d  = txd_q;
      new_d  = new_q;
      if (act_q & wr_q)
         case (addr_q)
            ADDR_CTRL:   ctrl_d = i_hwdata;
            ADDR_TIMING: tim_d = i_hwdata;
            ADDR_TXD:    txd_d = i_hwdata;
            ADDR_STAT:   new_d = new_q & ~i_hwdata[STAT_NEW];
            default:     ctrl_d = ctrl_q;
         endcase
      case (i_haddr[7:0])
         ADDR_CTRL:   rd_d = ctrl_q;
         ADDR_TIMING: rd_d = tim_q;
         ADDR_TXD:    rd_d = txd_q;
         ADDR_RXD:    rd_d = rxd_q;
         ADDR_STAT:   rd_d = {16'h0000, fcnt_q, 7'h00, new_q};
         default:     rd_d = 32'h00000000;
      endcase
      if (!(ap & ~i_hwrite))
         rd_d = 32'h00000000;
      dm     = ctrl_q[CTRL_MASTER];
      gen    = ctrl_q[CTRL_EN] & ~dm;
      halves = {1'b0, tim_q[TIM_BITS_LO +: 9], 1'b0};
      div_d  = div_q;
      bclk_d = bclk_q;
      mh_d   = mh_q;
      g_rise = 1'b0;
      g_fall = 1'b0;
      g_fs   = 1'b0;
      if (gen && div_q >= tim_q[TIM_DIV_LO +: 8] - 8'h01)
      begin
         div_d  = 8'h00;
         bclk_d = ~bclk_q;
         g_rise = ~bclk_q;
         g_fall = bclk_q;
         if (~bclk_q)
         begin
            g_fs = mh_q >= halves - 11'h001;
            mh_d = g_fs ? '0 : HC_W'(mh_q + 11'h001);
         end
      end
      else if (gen)
         div_d = div_q + 8'h01;
      fsa_d = gen & (mh_d < (ctrl_q[CTRL_DLY] ? DLY_HALVES : NONDLY_HALVES));
      rise  = gen ? g_rise : (dm & s2_q[0] & ~p_q[0]);
      fall  = gen ? g_fall : (dm & ~s2_q[0] & p_q[0]);
      fs    = gen ? g_fs : (dm & s2_q[1] & ~p_q[1]);
      hc_b  = fs ? '0 : hc_q;
      hc_d  = (rise && hc_b != '1) ? HC_W'(hc_b + 11'h001) : hc_b;
      fcnt_d = fs ? fcnt_q + 8'h01 : fcnt_q;
      bd    = hc_b[HC_W-1:1];
      bs    = 10'(hc_q[HC_W-1:1] - 10'h001);
      bxo_d = bxo_q;
      bxe_d = bxe_q;
      cap_d = cap_q;
      rxd_d = rxd_q;
      if (rise && !hc_b[0])
      begin
         bxe_d = ctrl_q[CTRL_EN] & (bd[9:5] == {2'b00, ctrl_q[CTRL_CH_LO +: 3]});
         bxo_d = txd_q[~bd[4:0]];
      end
      if (fall && !hc_q[0] && hc_q != '0 && bs[9:5] == {2'b00, ctrl_q[CTRL_CH_LO +: 3]})
      begin
         cap_d[~bs[4:0]] = s2_q[2];
         if (bs[4:0] == 5'h1F)
         begin
            rxd_d = cap_d;
            new_d = 1'b1; // set wins over a clear
         end
      end
   end
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         {s1_q, s2_q, p_q} <= '0;
         {ctrl_q, txd_q, rxd_q, cap_q} <= {CTRL_RST, IDLE_WORD, IDLE_WORD, IDLE_WORD};
         tim_q       <= TIM_RST;
         {addr_q, wr_q, act_q, new_q, fcnt_q} <= '0;
         {div_q, bclk_q, fsa_q, bxo_q, bxe_q} <= '0;
         mh_q        <= '1;
         hc_q        <= '1;
         o_hrdata    <= '0;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
      else
      begin
         s1_q        <= {link.br, link.primary_frame_sync, link.bclk};
         s2_q        <= s1_q;
         p_q         <= s2_q;
         {ctrl_q, tim_q, txd_q, rxd_q, cap_q} <= {ctrl_d, tim_d, txd_d, rxd_d, cap_d};
         addr_q      <= i_haddr[7:0];
         wr_q        <= i_hwrite;
         act_q       <= ap;
         new_q       <= new_d;
         fcnt_q      <= fcnt_d;
         {div_q, bclk_q, fsa_q, bxo_q, bxe_q} <= {div_d, bclk_d, fsa_d, bxo_d, bxe_d};
         mh_q        <= mh_d;
         hc_q        <= hc_d;
         o_hrdata    <= rd_d;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
   end
   // =====================================================
   // straps and drivers; low select pin released while the device is master
   assign link.ms_sel       = dm;
   assign link.mode_sel     = ctrl_q[CTRL_MODE];
   assign link.sel_hi       = dm ? ctrl_q[CTRL_RATE] : ctrl_q[CTRL_CH_LO + 2];
   assign link.sel_mid      = dm ? 1'b0 : ctrl_q[CTRL_CH_LO + 1];
   assign link.lo_host_o    = ctrl_q[CTRL_CH_LO];
   assign link.lo_host_oe   = ~dm;
   assign link.bclk_host_o  = bclk_q;
   assign link.bclk_host_oe = gen;
   assign link.fsa_host_o   = fsa_q;
   assign link.fsa_host_oe  = gen;
   assign link.bx_o         = bxo_q;
   assign link.bx_oe        = bxe_q;
endmodule : gci_host_end

// ==== testbench/gci_link_monitor.sv ====
// checker on the link wires between the two ends
// assumes it sees the link interface signals and the 25 MHz clock
`timescale 1ns/1ps
module gci_link_monitor (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // link wires
   input wire logic bclk,
   input wire logic bx,
   input wire logic ms_sel,
   input wire logic bclk_dev_oe,
   input wire logic fsa_dev_oe,
   input wire logic lo_dev_oe,
   input wire logic br_o,
   input wire logic br_oe
);
   // =====================================================
   // checks: straps get 8 cycles, the far end sees them through synchronisers
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   AST_SLV_NO_CLK: assert property ((!ms_sel) [*8] |-> !bclk_dev_oe && !fsa_dev_oe)
      else $error("slave device drives timing");
   AST_MST_CLK: assert property (ms_sel [*8] |-> bclk_dev_oe && fsa_dev_oe)
      else $error("master device not driving timing");
   AST_MST_SYNC_B: assert property (ms_sel [*8] |-> lo_dev_oe)
      else $error("master device not driving second sync");
   AST_SLV_STRAP: assert property ((!ms_sel) [*8] |-> !lo_dev_oe)
      else $error("slave device drives low strap pin");
   AST_BR_OPEN_DRAIN: assert property (br_oe |-> !br_o)
      else $error("answer line driven high");
   AST_BR_ON_RISE: assert property ($changed(br_oe) |-> bclk)
      else $error("answer line moved while clock low");
   AST_BR_HOLDS: assert property ($rose(br_oe) |=> br_oe [*8])
      else $error("answer bit too short");
   AST_BX_ON_RISE: assert property ($changed(bx) |-> bclk)
      else $error("send line moved while clock low");
endmodule : gci_link_monitor

// ==== testbench/isdn_tdm_gci_data_interface_tb_top.sv ====
// top testbench: host end and device end joined over the link interface
// assumes host registers on ahb-lite and a 32-word device send fifo
`timescale 1ns/1ps
module isdn_tdm_gci_data_interface_tb_top
   import gci_pkg::*;
;
   typedef struct {logic [31:0] ctrl, txd, word, exp; logic [7:0] sp; logic unf, chk;} row_s;
   // =====================================================
   // signals
   logic        i_mclk = 1'h0, i_rst = 1'h1;
   logic        hsel = 1'h0, hwrite = 1'h0, tx_valid = 1'h0, unf = 1'h0, cclr = 1'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = HSIZE_WORD;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, tx_word = 32'h0, hrdata, rx_word;
   logic [7:0]  sp = 8'h00;
   logic        hready, hresp, tx_ready, rx_valid, cont;
   int          n_mismatch = 0, samples_checked = 0, n_rxv = 0;
   row_s        rows [9] = '{
      '{32'h1, 32'h12345678, 32'hA5C30F96, 32'hA5C30F96, 8'h00, 1'h0, 1'h1},
      '{32'h1, 32'hFFFF0000, 32'h00FF00FE, 32'h00FF00FE, 8'h00, 1'h0, 1'h1},
      '{32'h9, 32'h0F0F0F0F, 32'h3C3C3C3C, 32'h3C3C3C3C, 8'h00, 1'h0, 1'h1},
      '{32'h21, 32'h5AA55AA5, 32'hC3C3C300, 32'hC3C3C300, 8'h00, 1'h0, 1'h1},
      '{32'h5, 32'h0, 32'h1, 32'h7FFFFFFF, 8'h00, 1'h0, 1'h0},
      '{32'h5, 32'h0, 32'h1, 32'hFFDFFFFF, 8'h05, 1'h0, 1'h0},
      '{32'h5, 32'h0, 32'h1, 32'hFFFFFDFF, 8'h0B, 1'h0, 1'h0},
      '{32'h5, 32'h0, 32'h1, 32'hFFFFFFFF, 8'h05, 1'h1, 1'h0},
      '{32'h3, 32'h76543210, 32'h8E8E8E8E, 32'h8E8E8E8E, 8'h00, 1'h0, 1'h1}};
   always #20 i_mclk = ~i_mclk;
   always @(posedge i_mclk) if (rx_valid === 1'h1) n_rxv++;
   // =====================================================
   // the two ends and the checker
   gci_if u_gci_if ();
   gci_host_end u_gci_host_end (.i_mclk(i_mclk), .i_rst(i_rst), .link(u_gci_if), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp));
   gci_dev_end u_gci_dev_end (.i_mclk(i_mclk), .i_rst(i_rst), .link(u_gci_if), .i_tx_word(tx_word),
      .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_word(rx_word), .o_rx_valid(rx_valid),
      .i_dslot_in(sp[7:2]), .i_dpair_in(sp[1:0]), .i_dslot_out(sp[7:2]), .i_dpair_out(sp[1:0]),
      .i_dport_unframed(unf), .o_contention(cont), .i_contention_clr(cclr));
   gci_link_monitor u_gci_link_monitor (.i_mclk(i_mclk), .i_rst(i_rst), .bclk(u_gci_if.bclk), .bx(u_gci_if.bx),
      .ms_sel(u_gci_if.ms_sel), .bclk_dev_oe(u_gci_if.bclk_dev_oe), .fsa_dev_oe(u_gci_if.fsa_dev_oe),
      .lo_dev_oe(u_gci_if.lo_dev_oe), .br_o(u_gci_if.br_o), .br_oe(u_gci_if.br_oe));
   // =====================================================
   // tasks
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (!ok)
      begin
         n_mismatch++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge i_mclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge i_mclk); while (hready !== 1'h1);
      rd = hrdata;
   endtask : ahb
   // waits past a frame start; the window words of the last frame are then settled
   task automatic frame();
      logic p;
      int   k = 0;
      do
      begin
         p = u_gci_if.primary_frame_sync;
         @(posedge i_mclk);
         k++;
      end
      while (!(u_gci_if.primary_frame_sync === 1'h1 && p === 1'h0) && k < 8000);
      chk(k < 8000, "no frame start");
      repeat (20) @(posedge i_mclk);
   endtask : frame
   task automatic push(input logic [31:0] w);
      tx_word <= w;
      tx_valid <= 1'h1;
      do @(posedge i_mclk); while (tx_ready !== 1'h1);
      tx_valid <= 1'h0;
   endtask : push
   task automatic stop_test();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   // =====================================================
   // sequence
   initial
   begin
      repeat (95000) @(posedge i_mclk);
      n_mismatch++;
      $display("MISMATCH %0t timeout", $time);
      stop_test();
   end
   initial
   begin
      logic [31:0] rd;
      int          na, nb, n;
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'h0;
      @(posedge i_mclk);
      chk(rx_word === IDLE_WORD && rx_valid === 1'h0 && cont === 1'h0, "reset outputs");
      chk(u_gci_if.br === 1'h1, "answer line held");
      ahb(1'h1, 8'h40, 32'hFFFFFFFF, rd);
      ahb(1'h0, 8'h40, 32'h0, rd);
      chk(rd === 32'h0, "unmapped read");
      ahb(1'h0, ADDR_CTRL, 32'h0, rd);
      chk(rd === CTRL_RST, "ctrl reset");
      ahb(1'h0, ADDR_TIMING, 32'h0, rd);
      chk(rd === TIM_RST, "timing reset");
      chk(tx_ready === 1'h1, "fifo not ready");
      // fill while the line drains one word a frame, then watch it empty
      ahb(1'h1, ADDR_TIMING, 32'h00040020, rd);
      ahb(1'h1, ADDR_CTRL, 32'h1, rd);
      frame();
      frame();
      n = 0;
      tx_word <= 32'hC0000000;
      tx_valid <= 1'h1;
      do
      begin
         @(posedge i_mclk);
         if (tx_ready === 1'h1) n++;
         tx_word <= 32'hC0000000 | n;
      end
      while (tx_ready === 1'h1 && n < 40);
      tx_valid <= 1'h0;
      chk(n == FIFO_DEPTH, "fifo depth");
      frame();
      for (int i = 0; i < 33; i++)
      begin
         frame();
         ahb(1'h0, ADDR_RXD, 32'h0, rd);
         chk(rd === (i < 32 ? 32'hC0000000 | i : IDLE_WORD), "fifo order");
      end
      chk(tx_ready === 1'h1, "fifo not drained");
      foreach (rows[r])
      begin
         ahb(1'h1, ADDR_TIMING, rows[r].ctrl[5] ? 32'h00040040 : 32'h00040020, rd);
         ahb(1'h1, ADDR_CTRL, rows[r].ctrl, rd);
         ahb(1'h1, ADDR_TXD, rows[r].txd, rd);
         sp <= rows[r].sp;
         unf <= rows[r].unf;
         frame();
         frame();
         push(rows[r].word);
         na = 0;
         nb = 0;
         repeat (5)
         begin
            frame();
            ahb(1'h0, ADDR_RXD, 32'h0, rd);
            nb += (rd === rows[r].exp);
            na += (rx_word === rows[r].txd);
         end
         chk(rows[r].unf ? nb == 5 : nb > 0, "line word");
         chk(!rows[r].chk || na > 0, "device word");
      end
      chk(cont === 1'h0, "false contention");
      cclr <= 1'h1;
      @(posedge i_mclk);
      cclr <= 1'h0;
      @(posedge i_mclk);
      chk(cont === 1'h0, "contention after clear");
      chk(n_rxv > 0, "no receive pulse");
      stop_test();
   end
endmodule : isdn_tdm_gci_data_interface_tb_top
